/* File: design/attr_bit_bank.sv */
/*
  bank of register bits, each obeying its attribute on software access.
  assumes accesses are already merged into one stream of single-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module attr_bit_bank
  import attr_pkg::*;
#(
  parameter int W = REG_WIDTH,
  parameter attr_t ATTR [W] = '{default: ATTR_RW},
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  sw_access_if.bank acc,
  input wire logic strap_load_i,
  input wire logic [W-1:0] strap_value_i,
  input wire logic [W-1:0] hw_set_i,
  input wire logic [W-1:0] hw_clr_i,
  input wire logic [W-1:0] hw_const_i,
  input wire logic unlock_i,
  output logic [W-1:0] value_o,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] bits;
  logic [W-1:0] next_bits;
  logic [W-1:0] next_rdata;
  logic qualify;

  ////////////////////////////////////////////////////////////////
  // any qualifier bit set in this write enables the other fields
  always_comb begin
    qualify = 1'b0;
    for (int i = 0; i < W; i++) begin
      if (ATTR[i] == ATTR_WQ && acc.wdata[i]) begin
        qualify = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // per-bit next value and read view
  always_comb begin
    logic has_wq;
    logic wr_ok;
    has_wq = 1'b0;
    wr_ok = 1'b0;
    for (int i = 0; i < W; i++) begin
      if (ATTR[i] == ATTR_WQ) begin
        has_wq = 1'b1;
      end
    end
    // without a qualifier field every write is permitted
    wr_ok = acc.wr && (!has_wq || qualify);
    next_bits = bits;
    next_rdata = rdata_o;
    for (int i = 0; i < W; i++) begin
      unique case (ATTR[i])
        ATTR_HW_INIT: begin
          // only the strap or eeprom load path writes it
          if (strap_load_i) begin
            next_bits[i] = strap_value_i[i];
          end
        end
        ATTR_RC: begin
          // writes ignored; read clears; set wins over clear
          if (acc.rd) begin
            next_bits[i] = 1'b0;
          end
          if (hw_set_i[i]) begin
            next_bits[i] = 1'b1;
          end
        end
        ATTR_RC_WRITABLE: begin
          if (acc.rd) begin
            next_bits[i] = 1'b0;
          end
          if (wr_ok) begin
            next_bits[i] = acc.wdata[i];
          end
          if (hw_set_i[i]) begin
            next_bits[i] = 1'b1;
          end
        end
        ATTR_RO: begin
          // status driven by hardware; software writes have no path
          if (hw_clr_i[i]) begin
            next_bits[i] = 1'b0;
          end
          if (hw_set_i[i]) begin
            next_bits[i] = 1'b1;
          end
        end
        ATTR_RW: begin
          if (wr_ok) begin
            next_bits[i] = acc.wdata[i];
          end
        end
        ATTR_W1C: begin
          // hardware never clears; hw_clr_i deliberately unused here
          if (wr_ok && acc.wdata[i]) begin
            next_bits[i] = 1'b0;
          end
          if (hw_set_i[i]) begin
            next_bits[i] = 1'b1;
          end
        end
        ATTR_LOCK_PROTECTED: begin
          if (wr_ok && unlock_i) begin
            next_bits[i] = acc.wdata[i];
          end
        end
        default: begin
          // qualifier, zero and reserved bits hold no state
          next_bits[i] = 1'b0;
        end
      endcase
      // read data captured at the strobe, old value before clear
      if (acc.rd) begin
        unique case (ATTR[i])
          ATTR_WQ, ATTR_ZERO: next_rdata[i] = 1'b0;
          ATTR_RSVD: next_rdata[i] = RSVD_READ_VALUE;
          default: begin
            // hardwired read-only bits show their constant, status bits their state
            next_rdata[i] = bits[i] | (ATTR[i] == ATTR_RO ? hw_const_i[i] : 1'b0);
          end
        endcase
      end
    end
  end

  // state and read data registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bits <= RESET_VALUE;
      rdata_o <= '0;
    end else begin
      bits <= next_bits;
      rdata_o <= next_rdata;
    end
  end

  assign value_o = bits;

  chk_w1c_hold_set : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (acc.wr && acc.wdata == '0 && hw_set_i == '0 && !strap_load_i)
    |=> (bits & ~$past(bits)) == '0)
    else $error("bit rose without set after zero write");
endmodule : attr_bit_bank
`default_nettype wire

/* File: design/register_attribute_access.sv */
/*
  merges root, smbus and eeprom writes into one software access stream
  and applies per-bit attributes through the bit bank.
  assumes each source holds its strobe until it sees its ack.
*/
`timescale 1ns/1ps
`default_nettype none
module register_attribute_access
  import attr_pkg::*;
#(
  parameter int W = REG_WIDTH,
  parameter attr_t ATTR [W] = '{default: ATTR_RW},
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic root_wr_i,
  input wire logic root_rd_i,
  input wire logic [W-1:0] root_wdata_i,
  input wire logic smb_wr_i,
  input wire logic smb_rd_i,
  input wire logic [W-1:0] smb_wdata_i,
  input wire logic eep_wr_i,
  input wire logic [W-1:0] eep_wdata_i,
  input wire logic [W-1:0] strap_pins_i,
  input wire logic [W-1:0] hw_set_i,
  input wire logic [W-1:0] hw_clr_i,
  input wire logic [W-1:0] hw_const_i,
  input wire logic register_write_unlock_i,
  output logic root_ack_o,
  output logic smb_ack_o,
  output logic eep_ack_o,
  output logic [W-1:0] rdata_o,
  output logic [W-1:0] value_o
);
  sw_access_if #(.W(W)) acc ();
  logic [W-1:0] strap_s1;
  logic [W-1:0] strap_s2;
  logic strap_done;
  logic next_strap_done;
  logic strap_load;
  logic unlock_s1;
  logic unlock_s2;
  src_t grant;

  ////////////////////////////////////////////////////////////////
  // positions of one attribute in this register; elaboration-time only
  function automatic logic [W-1:0] attr_mask(input attr_t a);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < W; i++) begin
      m[i] = (ATTR[i] == a);
    end
    return m;
  endfunction : attr_mask

  // masks used by the output checks below
  localparam logic [W-1:0] HW_INIT_BITS = attr_mask(ATTR_HW_INIT);
  localparam logic [W-1:0] RC_BITS = attr_mask(ATTR_RC);
  localparam logic [W-1:0] RO_BITS = attr_mask(ATTR_RO);
  localparam logic [W-1:0] W1C_BITS = attr_mask(ATTR_W1C);
  localparam logic [W-1:0] LOCK_BITS = attr_mask(ATTR_LOCK_PROTECTED);
  localparam logic [W-1:0] WQ_BITS = attr_mask(ATTR_WQ);
  localparam logic [W-1:0] ZERO_BITS = attr_mask(ATTR_ZERO);

  ////////////////////////////////////////////////////////////////
  // straps are pins: two flops before use
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      unlock_s1 <= 1'b0;
      unlock_s2 <= 1'b0;
      strap_done <= 1'b0;
    end else begin
      strap_s1 <= strap_pins_i;
      strap_s2 <= strap_s1;
      unlock_s1 <= register_write_unlock_i;
      unlock_s2 <= unlock_s1;
      strap_done <= next_strap_done;
    end
  end

  // latch straps once, two cycles after reset release when synced
  logic [1:0] strap_wait;
  logic [1:0] next_strap_wait;
  always_comb begin
    next_strap_wait = strap_wait;
    next_strap_done = strap_done;
    strap_load = 1'b0;
    if (!strap_done) begin
      if (strap_wait == 2'h2) begin
        strap_load = 1'b1;
        next_strap_done = 1'b1;
      end else begin
        next_strap_wait = strap_wait + 2'h1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      strap_wait <= 2'h0;
    end else begin
      strap_wait <= next_strap_wait;
    end
  end

  ////////////////////////////////////////////////////////////////
  // fixed priority arbiter: root, then smbus, then eeprom; losers wait
  always_comb begin
    acc.wr = 1'b0;
    acc.rd = 1'b0;
    acc.wdata = '0;
    root_ack_o = 1'b0;
    smb_ack_o = 1'b0;
    eep_ack_o = 1'b0;
    grant = SRC_ROOT;
    if (root_wr_i || root_rd_i) begin
      acc.wr = root_wr_i;
      acc.rd = root_rd_i;
      acc.wdata = root_wdata_i;
      root_ack_o = 1'b1;
    end else if (smb_wr_i || smb_rd_i) begin
      grant = SRC_SMBUS;
      acc.wr = smb_wr_i;
      acc.rd = smb_rd_i;
      acc.wdata = smb_wdata_i;
      smb_ack_o = 1'b1;
    end else if (eep_wr_i) begin
      grant = SRC_EEPROM;
      acc.wr = 1'b1;
      acc.wdata = eep_wdata_i;
      eep_ack_o = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // eeprom also loads hardware-initialized bits, same as straps
  logic hw_init_load;
  logic [W-1:0] hw_init_value;
  assign hw_init_load = strap_load || (grant == SRC_EEPROM && acc.wr);
  assign hw_init_value = strap_load ? strap_s2 : eep_wdata_i;

  attr_bit_bank #(
    .W(W),
    .ATTR(ATTR),
    .RESET_VALUE(RESET_VALUE)
  ) u_bank (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .acc(acc),
    .strap_load_i(hw_init_load),
    .strap_value_i(hw_init_value),
    .hw_set_i(hw_set_i),
    .hw_clr_i(hw_clr_i),
    .hw_const_i(hw_const_i),
    .unlock_i(unlock_s2),
    .value_o(value_o),
    .rdata_o(rdata_o)
  );

  ////////////////////////////////////////////////////////////////
  // checks on the arbiter grants, the strap load and what the bank shows at its outputs

  // one grant per cycle keeps the three sources from mixing
  chk_single_grant : assert property (@(posedge clk_i) disable iff (!nrst_i)
    $onehot0({root_ack_o, smb_ack_o, eep_ack_o}))
    else $error("more than one source granted");

  // the pin load happens once per reset
  chk_strap_once : assert property (@(posedge clk_i) disable iff (!nrst_i)
    strap_done |-> !strap_load)
    else $error("strap reloaded after init");

  // the load really lands the synced pin levels
  chk_strap_lands : assert property (@(posedge clk_i) disable iff (!nrst_i)
    strap_load |=> (value_o & HW_INIT_BITS) == ($past(strap_s2) & HW_INIT_BITS))
    else $error("strap value not loaded");

  // between loads the initialised bits never move
  chk_hw_init_hold : assert property (@(posedge clk_i) disable iff (!nrst_i)
    !hw_init_load |=> ((value_o ^ $past(value_o)) & HW_INIT_BITS) == '0)
    else $error("initialised bit changed without a load");

  // a read empties read-to-clear bits unless hardware sets them again
  chk_rc_read_clear : assert property (@(posedge clk_i) disable iff (!nrst_i)
    acc.rd |=> (value_o & ~$past(hw_set_i) & RC_BITS) == '0)
    else $error("read-to-clear bit survived a read");

  // read-only bits follow hardware only, whatever software writes
  chk_ro_hw_only : assert property (@(posedge clk_i) disable iff (!nrst_i)
    ((hw_set_i | hw_clr_i) & RO_BITS) == '0
    |=> ((value_o ^ $past(value_o)) & RO_BITS) == '0)
    else $error("read-only bit changed without hardware");

  // a write-one-to-clear bit falls only on a software write
  chk_w1c_no_hwclear : assert property (@(posedge clk_i) disable iff (!nrst_i)
    !acc.wr |=> (~value_o & $past(value_o) & W1C_BITS) == '0)
    else $error("write-one-to-clear bit cleared by hardware");

  // while locked the protected bits keep their value; the synced unlock decides
  chk_lock_holds : assert property (@(posedge clk_i) disable iff (!nrst_i)
    !unlock_s2 |=> ((value_o ^ $past(value_o)) & LOCK_BITS) == '0)
    else $error("lock-protected bit written while locked");

  // qualifier and hard-zero positions never read back as one
  chk_zero_reads : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rdata_o & (WQ_BITS | ZERO_BITS)) == '0)
    else $error("qualifier or zero bit read as one");
endmodule : register_attribute_access
`default_nettype wire

/* File: inc/attr_pkg.sv */
/*
  shared constants and types for the per-bit register attribute logic.
  assumes a single 25 MHz clock and a synchronous active-low reset.
*/
`default_nettype none
package attr_pkg;
  // attribute of one register bit
  typedef enum logic [3:0] {
    ATTR_HW_INIT = 4'h0,
    ATTR_RC = 4'h1,
    ATTR_RC_WRITABLE = 4'h2,
    ATTR_RO = 4'h3,
    ATTR_RW = 4'h4,
    ATTR_W1C = 4'h5,
    ATTR_LOCK_PROTECTED = 4'h6,
    ATTR_WQ = 4'h7,
    ATTR_ZERO = 4'h8,
    ATTR_RSVD = 4'h9
  } attr_t;
  localparam int REG_WIDTH = 32;
  localparam int CLK_PERIOD_NS = 40;
  // reserved bits read back this value; software must mask them anyway
  localparam logic RSVD_READ_VALUE = 1'b0;
  // source encoding of a software access
  typedef enum logic [1:0] {
    SRC_ROOT = 2'h0,
    SRC_SMBUS = 2'h1,
    SRC_EEPROM = 2'h2
  } src_t;
endpackage : attr_pkg
`default_nettype wire

/* File: inc/sw_access_if.sv */
/*
  interface carrying one merged software access to the bit cells.
  assumes one clock domain; the arbiter drives, the bit bank receives.
*/
`timescale 1ns/1ps
`default_nettype none
interface sw_access_if #(parameter int W = 32);
  logic wr;
  logic rd;
  logic [W-1:0] wdata;
  modport arb (output wr, output rd, output wdata);
  modport bank (input wr, input rd, input wdata);
endinterface : sw_access_if
`default_nettype wire

/* File: tb/sw_host.sv */
/*
  software access source: upstream root, smbus host or eeprom loader.
  assumes the block grants a strobe combinationally in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module sw_host #(
  parameter int W = 10,
  parameter logic [W-1:0] ZMASK = '0,
  parameter logic [W-1:0] RMASK = '0
) (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [W-1:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [W-1:0] wdata_o
);
  logic [W-1:0] last_rd = '0;
  // accesses that never saw a grant, judged by the bench at the end
  int misses = 0;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = '0;
  end
  // one access; strobe held until granted, a loser simply waits
  task automatic access(input logic is_rd, input logic [W-1:0] d, output logic [W-1:0] q);
    int n;
    n = 0;
    @(negedge clk_i);
    rd_o = is_rd;
    wr_o = !is_rd;
    wdata_o = (d & ~ZMASK & ~RMASK) | (last_rd & RMASK);
    @(posedge clk_i);
    while (ack_i !== 1'b1 && n < 64) begin
      n++;
      @(posedge clk_i);
    end
    if (ack_i !== 1'b1) begin
      misses++; // never granted
    end
    @(negedge clk_i);
    rd_o = 1'b0;
    wr_o = 1'b0;
    q = rdata_i;
    if (is_rd) begin
      last_rd = rdata_i;
    end
  endtask : access
endmodule : sw_host
`default_nettype wire

/* File: tb/tb_register_attribute_access.sv */
/*
  self-checking bench, one bit of each attribute in a 10-bit register.
  assumes sw_host models stand in for the three software sources.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_register_attribute_access;
  import attr_pkg::*;
  localparam int W = 10;
  localparam attr_t AT [W] = '{ATTR_HW_INIT, ATTR_RC, ATTR_RC_WRITABLE, ATTR_RO, ATTR_RW,
    ATTR_W1C, ATTR_LOCK_PROTECTED, ATTR_WQ, ATTR_ZERO, ATTR_RSVD};
  localparam logic [W-1:0] Q = 10'h080;
  // value of qualifier and reserved bits is not defined, so masked
  localparam logic [W-1:0] VM = 10'h17F;
  localparam logic [W-1:0] RM = 10'h1FF;
  // hard-zero and reserved positions, the same for every software source
  localparam logic [W-1:0] ZM = 10'h100;
  localparam logic [W-1:0] RS = 10'h200;
  // nonzero reset value so a missed reset shows on the read-write bit
  localparam logic [W-1:0] RV = 10'h010;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic unlock = 1'b0;
  logic [W-1:0] straps = 10'h001;
  logic [W-1:0] hw_set = '0;
  logic [W-1:0] hw_clr = '0;
  logic [W-1:0] hw_const = '0;
  logic r_wr, r_rd, s_wr, s_rd, e_wr, r_ack, s_ack, e_ack;
  logic [W-1:0] r_wd, s_wd, e_wd, rdata, value, q, exp;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 clk_i = ~clk_i;
  register_attribute_access #(.W(W), .ATTR(AT), .RESET_VALUE(RV)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .root_wr_i(r_wr), .root_rd_i(r_rd),
    .root_wdata_i(r_wd), .smb_wr_i(s_wr), .smb_rd_i(s_rd), .smb_wdata_i(s_wd),
    .eep_wr_i(e_wr), .eep_wdata_i(e_wd), .strap_pins_i(straps), .hw_set_i(hw_set),
    .hw_clr_i(hw_clr), .hw_const_i(hw_const), .register_write_unlock_i(unlock),
    .root_ack_o(r_ack), .smb_ack_o(s_ack), .eep_ack_o(e_ack), .rdata_o(rdata),
    .value_o(value));
  sw_host #(.W(W), .ZMASK(ZM), .RMASK(RS)) root (.clk_i(clk_i),
    .ack_i(r_ack), .rdata_i(rdata), .wr_o(r_wr), .rd_o(r_rd), .wdata_o(r_wd));
  sw_host #(.W(W), .ZMASK(ZM), .RMASK(RS)) smb (.clk_i(clk_i),
    .ack_i(s_ack), .rdata_i(rdata), .wr_o(s_wr), .rd_o(s_rd), .wdata_o(s_wd));
  sw_host #(.W(W), .ZMASK(ZM), .RMASK(RS)) eep (.clk_i(clk_i),
    .ack_i(e_ack), .rdata_i(rdata), .wr_o(e_wr), .rd_o(), .wdata_o(e_wd));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [W-1:0] e, input logic [W-1:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // two cycles let a registered update land before comparing
  task automatic cv(input string what);
    repeat (2) @(negedge clk_i);
    chk(what, exp & VM, value & VM);
  endtask : cv
  task automatic pulse(input logic [W-1:0] s, input logic [W-1:0] c);
    @(negedge clk_i);
    hw_set = s;
    hw_clr = c;
    @(negedge clk_i);
    hw_set = '0;
    hw_clr = '0;
  endtask : pulse
  task automatic conclude();
    check_count++;
    if (root.misses + smb.misses + eep.misses != 0) begin
      n_fail++;
      $display("Error host grants expected 0 misses seen %0d",
        root.misses + smb.misses + eep.misses);
    end
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////////////
  // hang guard, the run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    exp = RV | 10'h001;
    cv("strap load and reset value");
    // pins moving after the load must not reach the bit
    straps = 10'h000;
    root.access(1'b0, Q, q);
    exp[4] = 1'b0;
    cv("hw-init root write");
    eep.access(1'b0, Q, q);
    exp[0] = 1'b0;
    cv("hw-init eeprom load");
    smb.access(1'b0, Q | 10'h010, q);
    exp[4] = 1'b1;
    cv("rw smbus write");
    root.access(1'b1, '0, q);
    chk("rw root read", exp & RM, q & RM);
    eep.access(1'b0, Q, q);
    exp[4] = 1'b0;
    smb.access(1'b1, '0, q);
    chk("rw eeprom then smbus read", exp & RM, q & RM);
    pulse(10'h006, '0);
    exp[2:1] = 2'b11;
    root.access(1'b1, '0, q);
    chk("rc read value", exp & RM, q & RM);
    exp[2:1] = 2'b00;
    cv("rc cleared by read");
    root.access(1'b0, Q | 10'h006, q);
    exp[2] = 1'b1;
    cv("rc write");
    fork
      root.access(1'b1, '0, q);
      pulse(10'h006, '0);
    join
    exp[1] = 1'b1;
    cv("rc set beats read");
    root.access(1'b1, '0, q);
    exp[2:1] = 2'b00;
    pulse(10'h028, '0);
    exp[5] = 1'b1;
    exp[3] = 1'b1;
    cv("w1c ro hardware set");
    pulse('0, 10'h020);
    cv("w1c kept on hardware clear");
    root.access(1'b0, Q, q);
    cv("w1c ro zero write");
    root.access(1'b0, Q | 10'h028, q);
    exp[5] = 1'b0;
    cv("w1c one write");
    pulse('0, 10'h008);
    exp[3] = 1'b0;
    cv("ro hardware clear");
    fork
      smb.access(1'b0, Q | 10'h020, q);
      pulse(10'h020, '0);
    join
    exp[5] = 1'b1;
    cv("w1c set beats clear");
    root.access(1'b0, Q | 10'h040, q);
    cv("lock bit write while locked");
    unlock = 1'b1;
    repeat (4) @(negedge clk_i);
    smb.access(1'b0, Q | 10'h060, q);
    exp[6:5] = 2'b10;
    cv("lock bit write unlocked, w1c cleared");
    unlock = 1'b0;
    repeat (4) @(negedge clk_i);
    root.access(1'b0, 10'h010, q);
    cv("unqualified write");
    root.access(1'b0, '0, q);
    cv("all-zero write");
    root.access(1'b0, Q | 10'h010, q);
    exp[4] = 1'b1;
    cv("qualified write with lock");
    root.access(1'b1, '0, q);
    chk("locked bits readable", exp & RM, q & RM);
    // constant reaches read-only positions only, not the hw-init bit
    hw_const = 10'h009;
    root.access(1'b1, '0, q);
    chk("ro constant read", (exp | 10'h008) & RM, q & RM);
    hw_const = '0;
    fork
      root.access(1'b0, Q | 10'h010, q);
      smb.access(1'b0, Q, q);
    join
    exp[4] = 1'b0;
    cv("root before smbus");
    // second reset in mid-run: every bit back to reset value, pins load again
    straps = 10'h001;
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    exp = RV | 10'h001;
    cv("second reset");
    root.access(1'b1, '0, q);
    chk("read after second reset", exp & RM, q & RM);
    conclude();
  end
endmodule : tb_register_attribute_access
`default_nettype wire
